//--- core/mrs_defines.svh
// Constants for the memory map, remap and reset-source block.
// Assumes inclusion by bare name from core/ files.
`ifndef MRS_DEFINES_SVH
`define MRS_DEFINES_SVH

// =====================================================
// Address map
`define MRS_ALIAS_BASE 32'h0000_0000
`define MRS_ALIAS_SIZE 32'h0001_0000
`define MRS_SRAM_BASE 32'h0004_0000
`define MRS_SRAM_SIZE 32'h0000_1000
`define MRS_FLASH_BASE 32'h0008_0000
`define MRS_FLASH_SIZE 32'h0001_0000
`define MRS_BOOT_BASE 32'h0000_f800
`define MRS_PERIPH_BASE 32'hffff_f000
`define MRS_PERIPH_SIZE 32'h0000_1000
`define MRS_REG_PAGE 20'hffff0
`define MRS_LANE_LO16 4'h3
`define MRS_LANE_HI16 4'hc
`define MRS_LANE_ALL 4'hf
// =====================================================
// Peripheral registers
`define MRS_REMAP_ADDR 32'hffff_0220
`define MRS_RST_STATUS_ADDR 32'hffff_0230
`define MRS_RST_CLEAR_ADDR 32'hffff_0234
// =====================================================
// Fields
`define MRS_REMAP_BIT 0
`define MRS_RST_POR_BIT 0
`define MRS_RST_WDOG_BIT 1
`define MRS_RST_SOFT_BIT 2
`define MRS_RST_EXT_BIT 3
`define MRS_RST_USED_MASK 8'h0f
`define MRS_SRAM_IDX_LSB 2
`define MRS_SRAM_IDX_MSB 11
`define MRS_FLASH_OFF_MSB 15

`endif

//--- core/mrs_pkg.sv
// Types for the memory map, remap and reset-source block.
// Assumes mrs_defines.svh is compiled alongside.
package mrs_pkg;

  // =====================================================
  // Bus request from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mrs_req_t;

  // =====================================================
  // Decoded target
  typedef enum logic [5:0] {
    MRS_T_NONE = 6'h01,
    MRS_T_SRAM = 6'h02,
    MRS_T_FLASH = 6'h04,
    MRS_T_REG = 6'h08,
    MRS_T_PERIPH = 6'h10,
    MRS_T_ABORT = 6'h20
  } mrs_target_t;

endpackage : mrs_pkg

//--- core/mrs_memory_map.sv
// Functional notes
// R1 - Lowest 64 kB alias shows flash or SRAM per remap select.
// R2 - 4 kB peripheral register region sits at the top of the map.
// R3 - Access outside every defined region raises a data abort.
// R4 - Multi-byte data little endian, low byte at low address.
// R5 - 4 kB SRAM as 1024 words of 32 bits at 0x40000.
// R6 - SRAM serves 8, 16, 32 bit access and single-cycle fetches.
// R7 - Flash is 64 kB: 62 kB user, top 2 kB boot code.
// R8 - Exception vectors at 0x0..0x20 follow the memory mapped at zero.
// R9 - Remap bit 0 set maps SRAM at zero, clear maps flash.
// R10 - Every reset clears the remap bit.
// R11 - Software writes zero to remap bits 7 to 1.
// R12 - After reset core runs boot code then branches to address zero.
// R13 - Boot code region hidden from user code.
// R14 - Hardware sets status bit 3 external, 1 watchdog, 0 power-on.
// R15 - Writing 1 to status bit 2 starts software reset; bit reads set.
// R16 - Write-only clear register; 1 clears same status bit.
// R17 - Status bits 7 to 4 read zero.
// R18 - Clear write leaving soft flag set triggers another software reset.
// R19 - All resets reset peripherals except status; only power-on resets watchdog.
// R20 - SRAM kept across watchdog, soft, external; invalid after link download.
// R21 - After power-on SRAM intact only if flagging enabled and flag reads 1.
// R22 - Software issues remap from absolute flash address.
// R23 - Flash at physical 0x80000, at zero after hard reset.
// R24 - Alias forwards same offset; beyond memory size aborts.
//
// Address decoder, SRAM, remap and reset-source registers.
// Assumes one-cycle bus: answer valid the cycle after a request.
`timescale 1ns/1ns
`default_nettype none
`include "mrs_defines.svh"

module mrs_memory_map #(
  parameter int SRAM_WORDS = 1024,
  parameter int FLASH_USER_BYTES = 63488
) (
  input wire logic clk_sys, // 50 MHz system clock
  input wire logic rst_n, // Synchronous reset, any source
  input wire mrs_pkg::mrs_req_t req, // Core bus request
  input wire logic boot_mode, // Core running boot code
  input wire logic por_event, // Power-on reset pulse
  input wire logic wdog_event, // Watchdog reset pulse
  input wire logic ext_event, // External pin reset pulse
  input wire logic link_download, // Reset follows link download
  input wire logic lvf_enabled, // Low-voltage flagging enabled
  input wire logic lvf_status, // Low-voltage flag status
  input wire logic [31:0] flash_rdata, // Flash read data
  input wire logic [31:0] periph_rdata, // Other peripheral read data
  output logic [31:0] rdata, // Read data
  output logic ack, // Access done pulse
  output logic data_abort, // Abort pulse
  output logic [15:0] flash_addr, // Flash offset
  output logic flash_rd, // Flash read strobe
  output logic periph_sel, // Other peripheral access strobe
  output logic soft_reset_req, // Software reset request pulse
  output logic wdog_reset, // Watchdog reset, power-on only
  output logic sram_valid // SRAM contents trusted
);

  wire logic [31:0] sram_rword;
  mrs_pkg::mrs_target_t tgt;
  logic in_sram;
  logic in_flash;
  logic in_boot;
  logic is_remap_reg;
  logic is_status_reg;
  logic is_clear_reg;
  logic in_reg_page;
  logic in_top_page;
  logic reg_write;
  logic remap_wr;
  logic status_wr;
  logic clear_wr;
  logic soft_set;
  logic soft_again;
  logic [3:0] clear_mask;
  logic [3:0] cause_bits;
  logic any_cause;
  logic [31:0] flash_off;
  logic [31:0] eff_addr;
  logic [3:0] byte_en;
  logic [31:0] wmask_data;
  logic remap_q;
  logic [3:0] status_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic abort_q;
  logic [15:0] flash_addr_q;
  logic flash_rd_q;
  logic periph_sel_q;
  logic soft_q;
  logic wdog_q;
  logic valid_q;
  logic [9:0] sram_idx;
  logic alias_hit;

  // =====================================================
  // Address decode
  assign alias_hit = req.addr < `MRS_ALIAS_SIZE; // [R1]
  always_comb
  begin
    eff_addr = req.addr;
    tgt = mrs_pkg::MRS_T_NONE;
    if (alias_hit)
    begin
      // Same offset inside chosen memory [R24] [R8]
      eff_addr = (remap_q ? `MRS_SRAM_BASE : `MRS_FLASH_BASE) + req.addr; // [R1] [R9]
    end
    if (req.valid)
    begin
      if (in_sram)
      begin
        tgt = mrs_pkg::MRS_T_SRAM; // [R5]
      end
      else if (in_flash)
      begin
        // Boot area hidden outside boot mode [R13] [R7]
        if (in_boot && !boot_mode)
        begin
          tgt = mrs_pkg::MRS_T_ABORT;
        end
        else
        begin
          tgt = mrs_pkg::MRS_T_FLASH; // [R23]
        end
      end
      else if (is_remap_reg || is_status_reg || is_clear_reg)
      begin
        tgt = mrs_pkg::MRS_T_REG;
      end
      else if (in_top_page || in_reg_page)
      begin
        tgt = mrs_pkg::MRS_T_PERIPH; // [R2]
      end
      else
      begin
        tgt = mrs_pkg::MRS_T_ABORT; // [R3] [R24]
      end
    end
  end

  // =====================================================
  // Region hits: memories on the effective address, registers on the request address
  assign in_sram = eff_addr >= `MRS_SRAM_BASE &&
                   eff_addr < `MRS_SRAM_BASE + `MRS_SRAM_SIZE; // [R5]
  assign in_flash = eff_addr >= `MRS_FLASH_BASE &&
                    eff_addr < `MRS_FLASH_BASE + `MRS_FLASH_SIZE; // [R23]
  assign flash_off = eff_addr - `MRS_FLASH_BASE;
  assign in_boot = flash_off >= 32'(FLASH_USER_BYTES); // [R7]
  assign in_top_page = req.addr >= `MRS_PERIPH_BASE; // [R2]
  // Listed registers live in a lower page of the register area
  assign in_reg_page = req.addr[31:12] == `MRS_REG_PAGE;
  assign is_remap_reg = req.addr == `MRS_REMAP_ADDR;
  assign is_status_reg = req.addr == `MRS_RST_STATUS_ADDR;
  assign is_clear_reg = req.addr == `MRS_RST_CLEAR_ADDR;

  // =====================================================
  // Register write strobes
  assign reg_write = tgt == mrs_pkg::MRS_T_REG && req.write;
  assign remap_wr = reg_write && is_remap_reg; // [R9]
  assign status_wr = reg_write && is_status_reg;
  assign clear_wr = reg_write && is_clear_reg; // [R16]
  assign soft_set = status_wr && req.wdata[`MRS_RST_SOFT_BIT]; // [R15]
  assign soft_again = clear_wr && status_q[`MRS_RST_SOFT_BIT] &&
                      !req.wdata[`MRS_RST_SOFT_BIT]; // [R18]
  assign clear_mask = clear_wr ? req.wdata[3:0] : 4'h0; // [R16]
  assign any_cause = por_event || wdog_event || ext_event;

  // Single cause bit, power-on first [R14]
  always_comb
  begin
    cause_bits = 4'h0;
    if (por_event)
    begin
      cause_bits[`MRS_RST_POR_BIT] = 1'b1;
    end
    else if (wdog_event)
    begin
      cause_bits[`MRS_RST_WDOG_BIT] = 1'b1;
    end
    else if (ext_event)
    begin
      cause_bits[`MRS_RST_EXT_BIT] = 1'b1;
    end
  end

  // Little-endian byte lanes [R4] [R6]
  always_comb
  begin
    case (req.size)
      2'h0: byte_en = 4'h1 << req.addr[1:0];
      2'h1: byte_en = req.addr[1] ? `MRS_LANE_HI16 : `MRS_LANE_LO16;
      default: byte_en = `MRS_LANE_ALL;
    endcase
    case (req.size)
      2'h0: wmask_data = {4{req.wdata[7:0]}};
      2'h1: wmask_data = {2{req.wdata[15:0]}};
      default: wmask_data = req.wdata;
    endcase
  end

  assign sram_idx = eff_addr[`MRS_SRAM_IDX_MSB:`MRS_SRAM_IDX_LSB];

  // =====================================================
  // SRAM, never reset so contents survive [R20]
  // One byte-wide array per lane, so each lane has a single writer
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_lane
      logic [7:0] lane_mem [SRAM_WORDS];
      always_ff @(posedge clk_sys)
      begin
        if (tgt == mrs_pkg::MRS_T_SRAM && req.write && byte_en[gb])
        begin
          lane_mem[sram_idx] <= wmask_data[gb*8 +: 8]; // [R6]
        end
      end
      assign sram_rword[gb*8 +: 8] = lane_mem[sram_idx]; // [R4]
    end
  endgenerate

  // =====================================================
  // Remap select
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      remap_q <= 1'b0; // [R10] [R23]
    end
    else if (remap_wr)
    begin
      remap_q <= req.wdata[`MRS_REMAP_BIT]; // [R9] [R11]
    end
  end

  // =====================================================
  // Reset-source status, kept over rst_n [R19]
  always_ff @(posedge clk_sys)
  begin
    // Reset cause wins over a clear in the same cycle
    if (any_cause)
    begin
      status_q <= cause_bits; // [R14]
    end
    else
    begin
      status_q <= (status_q & ~clear_mask) | ({3'h0, soft_set} << `MRS_RST_SOFT_BIT); // [R15]
    end
  end

  // Software reset request pulse
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      soft_q <= 1'b0;
    else
      soft_q <= soft_set || soft_again; // [R15] [R18]
  end

  // Watchdog reset only from power-on
  always_ff @(posedge clk_sys)
  begin
    wdog_q <= por_event; // [R19]
  end

  // SRAM validity after each reset kind
  always_ff @(posedge clk_sys)
  begin
    if (por_event)
    begin
      valid_q <= lvf_enabled && lvf_status; // [R21]
    end
    else if (link_download && (wdog_event || ext_event || !rst_n))
    begin
      valid_q <= 1'b0; // [R20]
    end
    else if (wdog_event || ext_event)
    begin
      valid_q <= 1'b1; // [R20]
    end
  end

  // =====================================================
  // Answer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      abort_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      flash_rd_q <= 1'b0;
      periph_sel_q <= 1'b0;
      flash_addr_q <= 16'h0000;
    end
    else
    begin
      ack_q <= req.valid && tgt != mrs_pkg::MRS_T_ABORT;
      abort_q <= tgt == mrs_pkg::MRS_T_ABORT; // [R3]
      flash_rd_q <= tgt == mrs_pkg::MRS_T_FLASH && !req.write;
      periph_sel_q <= tgt == mrs_pkg::MRS_T_PERIPH;
      flash_addr_q <= eff_addr[`MRS_FLASH_OFF_MSB:0];
      case (tgt)
        mrs_pkg::MRS_T_SRAM: rdata_q <= sram_rword; // [R6]
        mrs_pkg::MRS_T_REG:
        begin
          if (is_remap_reg)
          begin
            rdata_q <= {31'h0, remap_q}; // [R9]
          end
          else if (is_status_reg)
          begin
            rdata_q <= {24'h0, {4'h0, status_q} & `MRS_RST_USED_MASK}; // [R17]
          end
          else
          begin
            // Clear register is write-only
            rdata_q <= 32'h0000_0000; // [R16]
          end
        end
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Flash and peripheral data pass from their own returns
  assign rdata = flash_rd_q ? flash_rdata : (periph_sel_q ? periph_rdata : rdata_q);
  assign ack = ack_q;
  assign data_abort = abort_q;
  assign flash_addr = flash_addr_q;
  assign flash_rd = flash_rd_q;
  assign periph_sel = periph_sel_q;
  assign soft_reset_req = soft_q; // [R12]
  assign wdog_reset = wdog_q;
  assign sram_valid = valid_q;

endmodule : mrs_memory_map
`default_nettype wire

//--- verif/mrs_map_checker.sv
// Port checker for the memory map block.
// Assumes the bind at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module mrs_map_checker (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire mrs_pkg::mrs_req_t req, // Request
  input wire logic boot_mode, // Boot code
  input wire logic por_event, // Power-on
  input wire logic [31:0] rdata, // Read data
  input wire logic ack, // Done
  input wire logic data_abort, // Abort
  input wire logic flash_rd, // Flash strobe
  input wire logic periph_sel, // Periph strobe
  input wire logic soft_reset_req, // Soft reset
  input wire logic wdog_reset // Watchdog reset
);
  logic remap_q;
  logic [31:0] a;
  logic v;
  assign a = req.addr;
  assign v = req.valid;
  // ====
  // Remap shadow
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      remap_q <= 1'b0;
    else if (v && req.write && a == 32'hffff_0220)
      remap_q <= req.wdata[0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_one_answer: assert property (v |=> ack ^ data_abort) else $error("answer");
  a_hole_abort: assert property (v && a[31:16] inside {[16'h1:16'h3]} |=> data_abort)
    else $error("hole");
  a_alias_bound: assert property (v && remap_q && a < 32'h1_0000 && a >= 32'h1000
    |=> data_abort) else $error("alias");
  a_boot_hidden: assert property (v && !boot_mode && a[31:11] == 21'h11f |=> data_abort)
    else $error("boot");
  a_alias_flash: assert property (v && !req.write && !remap_q && a < 32'hf800
    |=> flash_rd && ack) else $error("flash");
  a_top_periph: assert property (v && a[31:12] == 20'hfffff |=> ack && periph_sel)
    else $error("periph");
  a_soft_start: assert property (v && req.write && a == 32'hffff_0230 && req.wdata[2]
    |=> soft_reset_req) else $error("soft");
  a_remap_read: assert property (v && !req.write && a == 32'hffff_0220
    |=> rdata[0] == $past(remap_q)) else $error("remap");
  a_status_high: assert property (v && !req.write && a == 32'hffff_0230
    |=> rdata[7:4] == 4'h0) else $error("status");
  a_wdog_por: assert property (por_event |=> wdog_reset) else $error("wdog");
  cover property (v && req.write && a == 32'hffff_0220);
  cover property (soft_reset_req);
  cover property (data_abort);
endmodule : mrs_map_checker
bind mrs_memory_map mrs_map_checker u_chk (.*);
`default_nettype wire

//--- verif/mrs_core_model.sv
// Core bus model: one request, answer sampled a cycle later.
// Assumes the one-cycle answer of the map.
`timescale 1ns/1ns
`default_nettype none
module mrs_core_model (
  input wire logic clk_sys, // Clock
  input wire logic [31:0] rdata, // Read data
  input wire logic ack, // Done
  input wire logic data_abort, // Abort
  input wire logic soft_reset_req, // Soft reset
  output var mrs_pkg::mrs_req_t req // Request
);
  logic [31:0] rd;
  logic [1:0] st;
  logic sr;
  initial req = '0;
  // ====
  // Bus cycle
  task automatic bus(input logic w, input logic [1:0] sz, input logic [31:0] ad,
    input logic [31:0] wd);
    @(posedge clk_sys);
    req <= '{1'b1, w, !w && sz == 2'h2, sz, ad, wd};
    @(posedge clk_sys);
    req.valid <= 1'b0;
    req.wdata <= ~wd;
    #1;
    rd = rdata;
    st = {ack, data_abort};
    sr = soft_reset_req;
  endtask : bus
endmodule : mrs_core_model
`default_nettype wire

//--- verif/tb_mrs_memory_map.sv
// Self-checking bench for the memory map block.
// Assumes the core model drives the bus.
`timescale 1ns/1ns
`default_nettype none
module tb_mrs_memory_map;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic boot_mode = 1'b0, por_event = 1'b0, wdog_event = 1'b0, ext_event = 1'b0;
  logic link_download = 1'b0, lvf_enabled = 1'b1, lvf_status = 1'b1;
  logic [31:0] rdata;
  logic [15:0] flash_addr;
  logic ack, data_abort, flash_rd, periph_sel, soft_reset_req, wdog_reset, sram_valid;
  mrs_pkg::mrs_req_t req;
  int err_count = 0, total_checks = 0;
  wire logic [31:0] flash_rdata = {16'ha5c3, flash_addr};
  wire logic [31:0] periph_rdata = 32'h5a5a_0f0f;
  initial forever #10 clk_sys = ~clk_sys;
  mrs_memory_map u_dut (.*);
  mrs_core_model u_core (.*);
  // ====
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [31:0] ad);
    u_core.bus(1'b0, 2'h2, ad, 32'h0);
  endtask : rd
  task automatic wr(input logic [31:0] ad, input logic [31:0] wd);
    u_core.bus(1'b1, 2'h0, ad, wd);
  endtask : wr
  task automatic pulse(input logic [2:0] c);
    @(posedge clk_sys);
    {ext_event, wdog_event, por_event} <= c;
    @(posedge clk_sys);
    {ext_event, wdog_event, por_event} <= 3'h0;
    #1;
    chk(wdog_reset, c[0]);
    rd(32'hffff_0230);
  endtask : pulse
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // ====
  // Scenarios
  task automatic t_mem;
    u_core.bus(1'b1, 2'h2, 32'h0004_0000, 32'h4433_2211);
    u_core.bus(1'b1, 2'h0, 32'h0004_0002, 32'haaaa_aaaa);
    u_core.bus(1'b1, 2'h1, 32'h0004_0000, 32'hbbcc_bbcc);
    rd(32'h0004_0000);
    chk(u_core.rd, 32'h44aa_bbcc);
    rd(32'h0004_0ffc);
    chk(u_core.st, 2'h2);
    rd(32'h0004_1000);
    chk(u_core.st, 2'h1);
    rd(32'h0002_0000);
    chk(u_core.st, 2'h1);
    $display("t_mem done");
  endtask : t_mem
  task automatic t_remap;
    rd(32'h0000_0010);
    chk(u_core.rd, 32'ha5c3_0010);
    rd(32'h0008_0010);
    chk(u_core.rd, 32'ha5c3_0010);
    rd(32'h0008_f800);
    chk(u_core.st, 2'h1);
    boot_mode <= 1'b1;
    rd(32'h0008_f800);
    chk(u_core.st, 2'h2);
    boot_mode <= 1'b0;
    wr(32'hffff_0220, 32'h1);
    rd(32'h0);
    chk(u_core.rd, 32'h44aa_bbcc);
    rd(32'h0000_1000);
    chk(u_core.st, 2'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(32'h0);
    chk(u_core.rd, 32'ha5c3_0000);
    rd(32'h0004_0000);
    chk(u_core.rd, 32'h44aa_bbcc);
    rd(32'hffff_f000);
    chk(u_core.rd, 32'h5a5a_0f0f);
    $display("t_remap done");
  endtask : t_remap
  task automatic t_rst_src;
    pulse(3'h2);
    chk(u_core.rd[7:0], 8'h02);
    chk(sram_valid, 1'b1);
    link_download <= 1'b1;
    pulse(3'h4);
    chk(u_core.rd[7:0], 8'h08);
    chk(sram_valid, 1'b0);
    link_download <= 1'b0;
    lvf_status <= 1'b0;
    pulse(3'h1);
    chk(u_core.rd[7:0], 8'h01);
    chk(sram_valid, 1'b0);
    lvf_status <= 1'b1;
    pulse(3'h1);
    chk(sram_valid, 1'b1);
    wr(32'hffff_0234, 32'h1);
    rd(32'hffff_0230);
    chk(u_core.rd[7:0], 8'h00);
    wr(32'hffff_0230, 32'h4);
    chk(u_core.sr, 1'b1);
    rd(32'hffff_0230);
    chk(u_core.rd[7:0], 8'h04);
    wr(32'hffff_0234, 32'h1);
    chk(u_core.sr, 1'b1);
    wr(32'hffff_0234, 32'h4);
    chk(u_core.sr, 1'b0);
    rd(32'hffff_0230);
    chk(u_core.rd[7:0], 8'h00);
    wr(32'hffff_0230, 32'hf4);
    rd(32'hffff_0230);
    chk(u_core.rd[7:4], 4'h0);
    $display("t_rst_src done");
  endtask : t_rst_src
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    pulse(3'h1);
    t_mem();
    t_remap();
    t_rst_src();
    close_out();
  end
endmodule : tb_mrs_memory_map
`default_nettype wire
